//--- snco_dev.sv
// Sine/cosine oscillator: bus registers, phase accumulator, lookup, output shifters
//
// Contract
// - Zoom mode supplies sine and cosine streams
// - Source constant in baseband, sinusoid in fixed
// - Chirp sweeps from trigger; burst stops at length
// - Command then frequencies; then runs unattended
// - 32-bit loads; address picks accumulator register
// - Phase is unsigned fraction of full turn
// - Six accumulator registers; all used in chirp
// - 64-bit registers, upper 32 used, byte chunks
// - Phase advances by increment each sample period
// - Half-wave lookup, 13-bit phase, 16-bit amplitude
// - Interpolation added in four nibble chunks
// - Word latched, shifted out from next sync
// - Filter pulses sync; one value per pulse
// - Four-cycle super-cycle on two state bits
// - 01 housekeeping, 11 sine, 10 source
// - Phase, interpolate, shift: three-stage pipeline
// - Trigger latches cosine phase for readback
// - Self-test shifters readable with phase latch
// - Match needs address, strobes and I/O select
// - Ack low on match; transfer while strobe low
// - Three 16-bit load-and-shift output registers
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module snco_dev
	import snco_pkg::*;
#(
	parameter logic [3:0] DEV_BASE = DEV_BASE_DEF
)(
	// Clock and reset
	input logic CLK,
	input logic RSTN,
	// Link to controller
	snco_if.dev bus,
	// Status
	output logic [2:0] CUR_MODE,
	output logic SOURCE_RUN
);
	typedef struct packed {
		logic [2:0] mode;
		logic [31:0] stg;
		logic [ACC_W-1:0] flt_ph, flt_inc, src_ph, src_inc, crp_start, crp_rate;
		logic [15:0] bst_len, bst_cnt;
		logic run;
		logic [1:0] cs;
		logic [1:0] tick;
		logic cf, csr, sync_seen, adv;
		logic [PH_W-1:0] p2_ph;
		logic [1:0] p2_kind;
		logic p2_const, nc;
		logic [SMP_W-1:0] sum;
		logic [SMP_W-1:0] h_cos, h_sin, h_src;
		logic [SMP_W-1:0] sh_cos, sh_sin, sh_src;
		logic [4:0] shcnt;
		logic [SMP_W-1:0] st_cos, st_src;
		logic [PH_W-1:0] ph_latch;
		logic ack_n, done, oe;
		logic [7:0] dout;
	} snco_dev_t;
	snco_dev_t r;
	snco_dev_t n;

	// ***************************************************
	// Half-wave lookup: parabola stands in for the stored table
	// ***************************************************
	function automatic logic [15:0] sine_lut(input logic [12:0] x);
		logic [25:0] p;
		p = 26'(x) * 26'(13'h1000 - x);
		sine_lut = (p[25:22] != 4'h0) ? 16'h7FFF : (p[22] ? 16'h7FFF : {1'b0, p[21:7]});
	endfunction : sine_lut
	logic match, cin, chirp, src_const;
	logic [3:0] ra, frac;
	logic [11:0] idx;
	logic [15:0] base, nxt, itp, fin, val;
	logic [20:0] slope;
	logic [4:0] dsum;

	assign match = (bus.addr[7:4] == DEV_BASE) && !bus.address_strobe_n
		&& !bus.lower_data_strobe_n && !bus.io_space_select_n;
	assign ra = bus.addr[3:0];
	assign idx = r.p2_ph[30:19];
	assign frac = r.p2_ph[18:15];
	assign base = sine_lut({1'b0, idx});
	assign nxt = sine_lut({1'b0, idx} + 13'h1);
	assign slope = 21'($signed({1'b0, nxt}) - $signed({1'b0, base})) * 21'(frac);
	assign itp = slope[19:4];
	assign cin = (r.tick == 2'h0) ? 1'b0 : r.nc;
	assign dsum = {1'b0, base[4*r.tick +: 4]} + {1'b0, itp[4*r.tick +: 4]} + {4'h0, cin};
	assign fin = {dsum[3:0], r.sum[11:0]};
	assign val = r.p2_ph[31] ? 16'(-fin) : fin;
	assign chirp = (r.mode == MD_PCHIRP) || (r.mode == MD_BCHIRP);
	assign src_const = (r.mode == MD_BASE) || (r.mode == MD_IDLE) || (chirp && !r.run);

	always_comb
	begin
		n = r;
		// ***************************************************
		// Super-cycle and stage 2: nibble-serial interpolation add
		// ***************************************************
		n.tick = r.tick + 2'h1;
		n.nc = dsum[4];
		n.sum[4*r.tick +: 4] = dsum[3:0];
		if (r.tick == 2'h3)
		begin
			case (r.p2_kind)
				CS_COS:
				begin
					n.h_cos = val;
					if (r.mode == MD_ZOOM || r.mode == MD_SWEPT)
						n.h_src = val;
				end
				CS_SINE: n.h_sin = val;
				CS_SRC: n.h_src = r.p2_const ? SRC_CONST : val;
				default: ;
			endcase
			// Stage 1: phase for the cycle now ending feeds stage 2
			n.p2_kind = r.cs;
			n.p2_const = 1'b0;
			case (r.cs)
				CS_COS: n.p2_ph = r.flt_ph[63:32] + PH_QUARTER;
				CS_SINE: n.p2_ph = r.flt_ph[63:32];
				CS_SRC:
				begin
					n.p2_ph = r.src_ph[63:32];
					n.p2_const = src_const;
				end
				default: n.p2_ph = r.p2_ph;
			endcase
			case (r.cs)
				CS_COS: n.cs = CS_HOUSE;
				CS_HOUSE: n.cs = CS_SINE;
				CS_SINE: n.cs = CS_SRC;
				default: n.cs = CS_COS;
			endcase
		end
		// ***************************************************
		// Housekeeping: byte-chunk phase advance once per sync
		// ***************************************************
		// Advance starts only at tick 0: a sync landing mid-state must not add half a phase
		n.adv = (r.cs == CS_HOUSE) && ((r.tick == 2'h0) ? r.sync_seen : r.adv);
		if (n.adv)
		begin
			{n.cf, n.flt_ph[32 + 8*r.tick +: 8]} = {1'b0, r.flt_ph[32 + 8*r.tick +: 8]}
				+ {1'b0, r.flt_inc[32 + 8*r.tick +: 8]}
				+ {8'h00, (r.tick != 2'h0) & r.cf};
			if (!src_const)
				{n.csr, n.src_ph[32 + 8*r.tick +: 8]} = {1'b0, r.src_ph[32 + 8*r.tick +: 8]}
					+ {1'b0, r.src_inc[32 + 8*r.tick +: 8]}
					+ {8'h00, (r.tick != 2'h0) & r.csr};
			if (r.tick == 2'h0)
				n.sync_seen = 1'b0;
			if (r.tick == 2'h3 && chirp && r.run)
			begin
				n.src_inc = r.src_inc + r.crp_rate;
				n.bst_cnt = r.bst_cnt + 16'h1;
				if (r.mode == MD_BCHIRP && (r.bst_cnt + 16'h1) >= r.bst_len)
					n.run = 1'b0;
			end
		end
		// ***************************************************
		// Output shifters; sync from the filter starts a word
		// ***************************************************
		if (bus.sample_sync_pulse)
		begin
			n.sync_seen = 1'b1;
			n.sh_cos = r.h_cos;
			n.sh_sin = r.h_sin;
			n.sh_src = r.h_src;
			n.shcnt = SHIFT_LEN;
		end
		else if (r.shcnt != 5'h00)
		begin
			n.shcnt = r.shcnt - 5'h01;
			n.sh_cos = {r.sh_cos[14:0], 1'b0};
			n.sh_sin = {r.sh_sin[14:0], 1'b0};
			n.sh_src = {r.sh_src[14:0], 1'b0};
			n.st_cos = {r.st_cos[14:0], r.sh_cos[15]};
			n.st_src = {r.st_src[14:0], r.sh_src[15]};
		end
		// In the chirp modes, trigger overrides the housekeeping advance of the source phase
		if (bus.trigger)
		begin
			n.ph_latch = r.flt_ph[63:32] + PH_QUARTER;
			if (chirp)
			begin
				n.src_ph = '0;
				n.src_inc = r.crp_start;
				n.run = 1'b1;
				n.bst_cnt = 16'h0000;
			end
		end
		// ***************************************************
		// Processor bus slave: one transfer per address strobe
		// ***************************************************
		n.ack_n = !match;
		if (!match)
		begin
			n.done = 1'b0;
			n.oe = 1'b0;
		end
		else if (!r.ack_n && !bus.memory_valid_strobe_n && !r.done)
		begin
			n.done = 1'b1;
			if (bus.rd_wr_n)
			begin
				n.oe = 1'b1;
				case (ra)
					A_CMD: n.dout = {3'h0, r.cs, r.mode};
					4'h1: n.dout = r.ph_latch[7:0];
					4'h2: n.dout = r.ph_latch[15:8];
					4'h3: n.dout = r.ph_latch[23:16];
					4'h4: n.dout = r.ph_latch[31:24];
					A_ST_CH: n.dout = r.st_cos[15:8];
					A_ST_CL: n.dout = r.st_cos[7:0];
					A_ST_SH: n.dout = r.st_src[15:8];
					A_ST_SL: n.dout = r.st_src[7:0];
					default: n.dout = 8'h00;
				endcase
			end
			else
			begin
				case (ra)
					A_CMD:
					begin
						n.mode = bus.data_bus[2:0];
						n.flt_ph = '0;
						n.src_ph = '0;
						n.run = 1'b0;
						n.adv = 1'b0;
					end
					A_LD_SRC: n.src_inc = {r.stg, 32'h00000000};
					A_LD_CST: n.crp_start = {r.stg, 32'h00000000};
					A_LD_CRH: n.crp_rate[63:32] = r.stg;
					A_LD_CRL: n.crp_rate[31:0] = r.stg;
					A_LD_FLT: n.flt_inc = {r.stg, 32'h00000000};
					A_LD_BST: n.bst_len = r.stg[15:0];
					default:
						if (ra >= A_STG0 && ra <= A_STG3)
							n.stg[8*(ra - A_STG0) +: 8] = bus.data_bus;
				endcase
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			r <= '0;
			r.ack_n <= 1'b1;
		end
		else
			r <= n;
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	assign bus.peripheral_ack_n = r.ack_n;
	assign bus.d_dev = r.dout;
	assign bus.d_dev_oe = r.oe;
	assign bus.sine_stream = r.sh_sin[15];
	assign bus.cosine_stream = r.sh_cos[15];
	assign bus.source_sample_stream = r.sh_src[15];
	assign CUR_MODE = r.mode;
	assign SOURCE_RUN = r.run;
endmodule : snco_dev

//--- snco_pkg.sv
// Shared constants for the sine/cosine oscillator and its controller
package snco_pkg;
	// ***************************************************
	// Widths
	// ***************************************************
	localparam int ACC_W = 64;
	localparam int PH_W = 32;
	localparam int SMP_W = 16;
	localparam int LUT_AW = 12;
	localparam int FRAC_W = 4;
	localparam logic [4:0] SHIFT_LEN = 5'h10;
	// ***************************************************
	// Device base (high address nibble) and register index (low nibble)
	// ***************************************************
	localparam logic [3:0] DEV_BASE_DEF = 4'h3;
	localparam logic [3:0] A_CMD = 4'h0;
	localparam logic [3:0] A_STG0 = 4'h1;
	localparam logic [3:0] A_STG3 = 4'h4;
	localparam logic [3:0] A_LD_SRC = 4'h5;
	localparam logic [3:0] A_LD_CST = 4'h6;
	localparam logic [3:0] A_LD_CRH = 4'h7;
	localparam logic [3:0] A_LD_CRL = 4'h8;
	localparam logic [3:0] A_LD_FLT = 4'h9;
	localparam logic [3:0] A_LD_BST = 4'hA;
	localparam logic [3:0] A_ST_CH = 4'hB;
	localparam logic [3:0] A_ST_CL = 4'hC;
	localparam logic [3:0] A_ST_SH = 4'hD;
	localparam logic [3:0] A_ST_SL = 4'hE;
	// ***************************************************
	// Operating modes (command byte, low three bits)
	// ***************************************************
	localparam logic [2:0] MD_IDLE = 3'h0;
	localparam logic [2:0] MD_BASE = 3'h1;
	localparam logic [2:0] MD_ZOOM = 3'h2;
	localparam logic [2:0] MD_SWEPT = 3'h3;
	localparam logic [2:0] MD_PCHIRP = 3'h4;
	localparam logic [2:0] MD_BCHIRP = 3'h5;
	localparam logic [2:0] MD_FIXED = 3'h6;
	// ***************************************************
	// Super-cycle states {high, low}
	// ***************************************************
	localparam logic [1:0] CS_COS = 2'h0;
	localparam logic [1:0] CS_HOUSE = 2'h1;
	localparam logic [1:0] CS_SINE = 2'h3;
	localparam logic [1:0] CS_SRC = 2'h2;
	localparam logic [31:0] PH_QUARTER = 32'h40000000;
	localparam logic [15:0] SRC_CONST = 16'h7FFF;
	// ***************************************************
	// Controller
	// ***************************************************
	localparam int ENA_DIV_DEF = 4;
	localparam int SYNC_DIV_DEF = 64;
	localparam logic [7:0] W_CMD = 8'h00;
	localparam logic [7:0] W_STAT = 8'h04;
	localparam logic [7:0] W_TRIG = 8'h08;
	localparam logic [7:0] W_SMP = 8'h0C;
	localparam logic [7:0] W_SRC = 8'h10;
	typedef enum logic [2:0] {H_IDLE, H_WAITACK, H_VMA1, H_VMA2} snco_hst_t;
endpackage : snco_pkg

//--- snco_if.sv
// Processor bus and sample streams between oscillator and controller
`timescale 1ns/1ps
interface snco_if;
	logic [7:0] addr;
	logic rd_wr_n;
	logic address_strobe_n;
	logic lower_data_strobe_n;
	logic io_space_select_n;
	logic memory_valid_strobe_n;
	logic bus_enable_clock_n;
	logic peripheral_ack_n;
	logic [7:0] d_host;
	logic d_host_oe;
	logic [7:0] d_dev;
	logic d_dev_oe;
	logic [7:0] data_bus;
	logic sample_sync_pulse;
	logic trigger;
	logic sine_stream;
	logic cosine_stream;
	logic source_sample_stream;
	// Pulled-up bus when nobody drives
	assign data_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hFF);
	modport dev (input addr, rd_wr_n, address_strobe_n, lower_data_strobe_n, io_space_select_n,
		memory_valid_strobe_n, bus_enable_clock_n, data_bus, sample_sync_pulse, trigger,
		output peripheral_ack_n, d_dev, d_dev_oe, sine_stream, cosine_stream,
		source_sample_stream);
	modport host (output addr, rd_wr_n, address_strobe_n, lower_data_strobe_n, io_space_select_n,
		memory_valid_strobe_n, bus_enable_clock_n, d_host, d_host_oe, sample_sync_pulse, trigger,
		input peripheral_ack_n, data_bus, sine_stream, cosine_stream, source_sample_stream);
endinterface : snco_if

//--- snco_host.sv
// Controller end: Wishbone slave, processor-bus master, sync source, stream receiver
`timescale 1ns/1ps
module snco_host
	import snco_pkg::*;
#(
	parameter int ENA_DIV = ENA_DIV_DEF,
	parameter int SYNC_DIV = SYNC_DIV_DEF
)(
	// Clock and reset
	input logic CLK,
	input logic RSTN,
	// Wishbone slave
	input logic WB_CYC,
	input logic WB_STB,
	input logic WB_WE,
	input logic [7:0] WB_ADR,
	input logic [3:0] WB_SEL,
	input logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK,
	// Link to oscillator
	snco_if.host bus
);
	// ***************************************************
	// Elaboration checks
	// ***************************************************
	if (ENA_DIV < 2 || ENA_DIV > 4)
	begin : g_ena_chk
		$error("ENA_DIV must lie in 2..4");
	end
	if (SYNC_DIV < 32 || SYNC_DIV > 256)
	begin : g_sync_chk
		$error("SYNC_DIV must lie in 32..256");
	end

	typedef struct packed {
		snco_hst_t st;
		logic ack;
		logic [31:0] dat_o;
		logic busy;
		logic [7:0] rdata;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic rw;
		logic as_n;
		logic vma_n;
		logic d_oe;
		logic ena_n;
		logic [1:0] ediv;
		logic [7:0] sdiv;
		logic sync;
		logic trig;
		logic [4:0] rcnt;
		logic [15:0] rx_cos;
		logic [15:0] rx_sin;
		logic [15:0] rx_src;
		logic [15:0] w_cos;
		logic [15:0] w_sin;
		logic [15:0] w_src;
	} snco_hreg_t;

	snco_hreg_t r;
	snco_hreg_t n;
	logic req;

	assign req = WB_CYC && WB_STB && !r.ack;

	always_comb
	begin
		n = r;
		// ***************************************************
		// Dividers: enable clock and sample sync
		// ***************************************************
		n.ediv = (r.ediv == 2'(ENA_DIV - 1)) ? 2'h0 : r.ediv + 2'h1;
		n.ena_n = (n.ediv != 2'h0);
		n.sdiv = (r.sdiv == 8'(SYNC_DIV - 1)) ? 8'h00 : r.sdiv + 8'h01;
		n.sync = (r.sdiv == 8'(SYNC_DIV - 1));
		n.trig = 1'b0;
		// ***************************************************
		// Wishbone: answer one cycle after the request
		// ***************************************************
		n.ack = req;
		if (req)
		begin
			if (WB_WE)
			begin
				if (WB_ADR == W_CMD && WB_SEL[0] && !r.busy)
				begin
					n.busy = 1'b1;
					n.wdata = WB_DAT_I[7:0];
					n.addr = WB_DAT_I[15:8];
					n.rw = !WB_DAT_I[16];
				end
				if (WB_ADR == W_TRIG)
					n.trig = 1'b1;
			end
			else
			begin
				case (WB_ADR)
					W_STAT: n.dat_o = {16'h0000, r.rdata, 7'h00, r.busy};
					W_SMP: n.dat_o = {r.w_sin, r.w_cos};
					W_SRC: n.dat_o = {16'h0000, r.w_src};
					default: n.dat_o = 32'h00000000;
				endcase
			end
		end
		// ***************************************************
		// Processor bus cycle toward the oscillator
		// ***************************************************
		case (r.st)
			H_IDLE:
				if (r.busy)
				begin
					n.as_n = 1'b0;
					n.d_oe = !r.rw;
					n.st = H_WAITACK;
				end
			H_WAITACK:
				if (!bus.peripheral_ack_n && !r.ena_n)
				begin
					n.vma_n = 1'b0;
					n.st = H_VMA1;
				end
			H_VMA1: n.st = H_VMA2;
			H_VMA2:
			begin
				if (r.rw)
					n.rdata = bus.data_bus;
				n.as_n = 1'b1;
				n.vma_n = 1'b1;
				n.d_oe = 1'b0;
				n.busy = 1'b0;
				n.st = H_IDLE;
			end
			default: n.st = H_IDLE;
		endcase
		// ***************************************************
		// Serial receive: one word per sync on each stream
		// ***************************************************
		if (r.sync)
			n.rcnt = 5'h10;
		else if (r.rcnt != 5'h00)
		begin
			n.rcnt = r.rcnt - 5'h01;
			n.rx_cos = {r.rx_cos[14:0], bus.cosine_stream};
			n.rx_sin = {r.rx_sin[14:0], bus.sine_stream};
			n.rx_src = {r.rx_src[14:0], bus.source_sample_stream};
			if (r.rcnt == 5'h01)
			begin
				n.w_cos = {r.rx_cos[14:0], bus.cosine_stream};
				n.w_sin = {r.rx_sin[14:0], bus.sine_stream};
				n.w_src = {r.rx_src[14:0], bus.source_sample_stream};
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			r <= '0;
			r.st <= H_IDLE;
			r.as_n <= 1'b1;
			r.vma_n <= 1'b1;
			r.ena_n <= 1'b1;
			r.rw <= 1'b1;
		end
		else
			r <= n;
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	assign WB_ACK = r.ack;
	assign WB_DAT_O = r.dat_o;
	assign bus.addr = r.addr;
	assign bus.rd_wr_n = r.rw;
	assign bus.address_strobe_n = r.as_n;
	assign bus.lower_data_strobe_n = r.as_n;
	assign bus.io_space_select_n = r.as_n;
	assign bus.memory_valid_strobe_n = r.vma_n;
	assign bus.bus_enable_clock_n = r.ena_n;
	assign bus.d_host = r.wdata;
	assign bus.d_host_oe = r.d_oe;
	assign bus.sample_sync_pulse = r.sync;
	assign bus.trigger = r.trig;
endmodule : snco_host

//--- snco_checker.sv
// Checker for the link between oscillator and controller
`timescale 1ns/1ps
module snco_checker
	import snco_pkg::*;
#(
	parameter logic [3:0] DEV_BASE = DEV_BASE_DEF,
	parameter int SYNC_DIV = SYNC_DIV_DEF
)(
	// Clock and reset
	input logic CLK,
	input logic RSTN,
	// Processor bus
	input logic [7:0] addr,
	input logic rd_wr_n,
	input logic address_strobe_n,
	input logic lower_data_strobe_n,
	input logic io_space_select_n,
	input logic memory_valid_strobe_n,
	input logic peripheral_ack_n,
	input logic d_dev_oe,
	// Streams
	input logic sample_sync_pulse,
	input logic sine_stream,
	input logic cosine_stream,
	input logic source_sample_stream
);
	// ***************************************************
	// Clocks since the last sync
	// ***************************************************
	typedef struct packed {logic [7:0] gap; logic seen;} snco_chk_t;
	snco_chk_t chk_r;
	snco_chk_t chk_nxt;
	always_comb
	begin
		chk_nxt.gap = sample_sync_pulse ? 8'h00 : chk_r.gap + 8'h01;
		chk_nxt.seen = chk_r.seen | sample_sync_pulse;
	end
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			chk_r <= '0;
		else
			chk_r <= chk_nxt;
	end
	// ***************************************************
	// Properties
	// ***************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence matched_s;
		!address_strobe_n && !lower_data_strobe_n && !io_space_select_n && addr[7:4] == DEV_BASE;
	endsequence
	sequence vma_pulse_s;
		!memory_valid_strobe_n [*2] ##1 memory_valid_strobe_n;
	endsequence
	strobes_equal_a: assert property (
		lower_data_strobe_n == address_strobe_n && io_space_select_n == address_strobe_n)
		else $error("bus strobes differ");
	ack_on_match_a: assert property (
		!peripheral_ack_n |-> !$past(address_strobe_n) && ($past(addr) >> 4) == 8'(DEV_BASE))
		else $error("ack without address match");
	ack_follows_a: assert property (matched_s |=> !peripheral_ack_n)
		else $error("no ack after match");
	ack_drop_a: assert property (address_strobe_n |=> peripheral_ack_n)
		else $error("ack held without strobe");
	vma_pulse_a: assert property ($fell(memory_valid_strobe_n) |-> vma_pulse_s)
		else $error("valid strobe not two cycles");
	vma_acked_a: assert property (!memory_valid_strobe_n |-> !peripheral_ack_n)
		else $error("valid strobe without ack");
	oe_read_a: assert property (d_dev_oe |-> rd_wr_n)
		else $error("device drives data on write");
	sync_period_a: assert property (
		sample_sync_pulse && chk_r.seen |-> chk_r.gap == 8'(SYNC_DIV - 1))
		else $error("sync period wrong");
	sync_single_a: assert property (sample_sync_pulse |=> !sample_sync_pulse [*8])
		else $error("sync too close");
	stream_rest_a: assert property (
		sample_sync_pulse |-> ##17 !(sine_stream | cosine_stream | source_sample_stream))
		else $error("stream not idle after word");
endmodule : snco_checker

//--- sine_cosine_nco_bench.sv
// Bench: controller and oscillator joined, driven over Wishbone
`timescale 1ns/1ps
module sine_cosine_nco_bench import snco_pkg::*;;
	typedef struct packed {logic [31:0] val; logic [31:0] msk;} snco_exp_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_di = 32'h0;
	logic [31:0] wb_do;
	logic wb_ack;
	logic [2:0] cur_mode;
	logic src_run;
	int err_total = 0;
	int samples_checked = 0;
	int seed = 32'h59E7C348;
	snco_exp_t exp_q[$];
	snco_if link();
	always #50 clk = ~clk;
	snco_dev u_snco_dev (.CLK(clk), .RSTN(rstn), .bus(link), .CUR_MODE(cur_mode),
		.SOURCE_RUN(src_run));
	snco_host #(.SYNC_DIV(32)) u_snco_host (.CLK(clk), .RSTN(rstn), .WB_CYC(wb_cyc),
		.WB_STB(wb_stb), .WB_WE(wb_we), .WB_ADR(wb_adr), .WB_SEL(wb_sel), .WB_DAT_I(wb_di),
		.WB_DAT_O(wb_do), .WB_ACK(wb_ack), .bus(link));
	snco_checker #(.SYNC_DIV(32)) u_snco_checker (.CLK(clk), .RSTN(rstn), .addr(link.addr),
		.rd_wr_n(link.rd_wr_n), .address_strobe_n(link.address_strobe_n),
		.lower_data_strobe_n(link.lower_data_strobe_n), .io_space_select_n(link.io_space_select_n),
		.memory_valid_strobe_n(link.memory_valid_strobe_n),
		.peripheral_ack_n(link.peripheral_ack_n), .d_dev_oe(link.d_dev_oe),
		.sample_sync_pulse(link.sample_sync_pulse), .sine_stream(link.sine_stream),
		.cosine_stream(link.cosine_stream), .source_sample_stream(link.source_sample_stream));
	// ***************************************************
	// Reporting and comparison
	// ***************************************************
	task automatic finish_test;
		$display("compared %0d, mismatched %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic fail(input string msg);
		err_total++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask : fail
	task automatic hang;
		fail("wait ran out");
		finish_test();
	endtask : hang
	task automatic chk_rd(input logic [31:0] got, input snco_exp_t e);
		samples_checked++;
		if ((got & e.msk) !== (e.val & e.msk))
			fail($sformatf("read %h want %h", got, e.val));
	endtask : chk_rd
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string s);
		samples_checked++;
		if (got !== exp)
			fail($sformatf("%s %h want %h", s, got, exp));
	endtask : chk_val
	// Read results are matched in issue order as the acks come back
	always @(posedge clk)
	begin
		if (wb_ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0)
		begin
			if (exp_q.size() == 0)
				fail("read with no note");
			else
				chk_rd(wb_do, exp_q.pop_front());
		end
	end
	// ***************************************************
	// Bus and stream tasks
	// ***************************************************
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] di,
		output logic [31:0] dq);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_di <= di;
		wb_sel <= 4'hF;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 40);
		if (n >= 40)
			hang();
		dq = wb_do;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk);
	endtask : wb_cycle
	task automatic wb_wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] dq;
		wb_cycle(1'b1, adr, d, dq);
	endtask : wb_wr
	task automatic wb_rd(input logic [7:0] adr, input logic [31:0] e, input logic [31:0] m,
		output logic [31:0] dq);
		exp_q.push_back('{val: e, msk: m});
		wb_cycle(1'b0, adr, 32'h0, dq);
	endtask : wb_rd
	task automatic wait_idle;
		logic [31:0] st;
		int n;
		n = 0;
		do
		begin
			wb_rd(W_STAT, 32'h0, 32'h0, st);
			n++;
		end
		while (st[0] !== 1'b0 && n < 30);
		if (n >= 30)
			hang();
	endtask : wait_idle
	task automatic dev_wr(input logic [3:0] idx, input logic [7:0] d);
		wb_wr(W_CMD, {15'h0, 1'b1, DEV_BASE_DEF, idx, d});
		wait_idle();
	endtask : dev_wr
	task automatic dev_rd(input logic [3:0] idx, input logic [7:0] e, input logic [7:0] m);
		logic [31:0] dq;
		wb_wr(W_CMD, {15'h0, 1'b0, DEV_BASE_DEF, idx, 8'h00});
		wait_idle();
		wb_rd(W_STAT, {16'h0, e, 8'h00}, {16'h0, m, 8'h00}, dq);
	endtask : dev_rd
	task automatic load32(input logic [3:0] idx, input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			dev_wr(A_STG0 + 4'(i), v[8*i +: 8]);
		dev_wr(idx, 8'h00);
	endtask : load32
	// Word shifted out after the next sync: 0 sine, 1 cosine, 2 source
	task automatic cap(input int which, output logic [15:0] w);
		int n;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (link.sample_sync_pulse !== 1'b1 && n < 80);
		if (n >= 80)
			hang();
		for (int i = 15; i >= 0; i--)
		begin
			@(negedge clk);
			w[i] = which == 0 ? link.sine_stream : which == 1 ? link.cosine_stream :
				link.source_sample_stream;
		end
		@(posedge clk);
	endtask : cap
	// ***************************************************
	// Main sequence
	// ***************************************************
	initial
	begin
		logic [31:0] dq;
		logic [15:0] w;
		logic [2:0] nz;
		logic sg;
		nz = 3'h0;
		sg = 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk_val(16'(cur_mode), 16'(MD_IDLE), "mode");
		chk_val(16'(src_run), 16'h0, "run");
		wb_wr(8'hF4, $random(seed));
		wb_rd(8'hF0, 32'h0, 32'hFFFFFFFF, dq);
		$display("test reset done");
		for (int m = 0; m < 7; m++)
		begin
			dev_wr(A_CMD, {5'h0, 3'(m)});
			chk_val(16'(cur_mode), 16'(m), "mode");
			dev_rd(A_CMD, {5'h0, 3'(m)}, 8'h07);
		end
		$display("test modes done");
		wb_wr(W_CMD, {15'h0, 1'b1, DEV_BASE_DEF, A_CMD, 5'h0, MD_BASE});
		wb_wr(W_CMD, {15'h0, 1'b1, DEV_BASE_DEF, A_CMD, 5'h0, MD_ZOOM});
		wait_idle();
		chk_val(16'(cur_mode), 16'(MD_BASE), "busy cmd");
		repeat (3) cap(2, w);
		chk_val(w, SRC_CONST, "constant");
		wb_rd(W_SRC, {16'h0, SRC_CONST}, 32'h0000FFFF, dq);
		$display("test baseband done");
		dev_wr(A_CMD, {5'h0, MD_ZOOM});
		load32(A_LD_FLT, 32'h0);
		repeat (3) cap(0, w);
		chk_val(w, 16'h0000, "sine at zero");
		cap(1, w);
		chk_val(16'({w[15], w != 16'h0}), 16'h0001, "cosine at zero");
		wb_rd(W_SMP, 32'h0, 32'hFFFF0000, dq);
		wb_wr(W_TRIG, 32'h0);
		for (int b = 1; b < 4; b++)
			dev_rd(4'(b), 8'h00, 8'hFF);
		dev_rd(4'h4, PH_QUARTER[31:24], 8'hFF);
		$display("test zoom done");
		dev_wr(A_CMD, {5'h0, MD_FIXED});
		load32(A_LD_SRC, PH_QUARTER);
		repeat (3) cap(2, w);
		for (int k = 0; k < 4; k++)
		begin
			cap(2, w);
			nz += 3'(w != 16'h0);
			sg ^= (w != 16'h0) & w[15];
		end
		chk_val({12'h0, sg, nz}, 16'h000A, "quarter steps");
		$display("test fixed done");
		for (int i = 0; i < 2; i++)
		begin
			dev_wr(A_CMD, {5'h0, i ? MD_BCHIRP : MD_PCHIRP});
			load32(A_LD_CST, $random(seed));
			load32(A_LD_CRH, $random(seed));
			load32(A_LD_CRL, $random(seed));
			load32(A_LD_BST, 32'h2);
			wb_wr(W_TRIG, 32'h0);
			repeat (4) @(posedge clk);
			chk_val(16'(src_run), 16'h1, "sweep on");
			repeat (192) @(posedge clk);
			chk_val(16'(src_run), i ? 16'h0 : 16'h1, "sweep end");
		end
		$display("test chirp done");
		finish_test();
	end
endmodule : sine_cosine_nco_bench
